// File: rtl/srf_fault_ctrl.sv
// Fault response and enable control for the step-down and step-up rails.
//
// How it works
// - Step-down overvoltage: SAFE, disable, flag, count, interrupt.
// - Then RESET on undervoltage if option set.
// - Persisting overvoltage after disable: OFF, latch.
// - Step-up enable reads set after reset.
// - Soft-start after wide ramp, linear 2 ms.
// - Soft-start restarts after any shutdown.
// - Output monitor events set own status bits.
// - High-side overload flags, converter keeps running.
// - Short: low-side off, drain, then full shutdown.
// - After short, RESET on undervoltage if option.
// - Sink overcurrent flags; over 20 us acts as short.
// - Sink events masked from an enable write until output above undervoltage.
// - Re-enable under current limit: off again, count.
// - Thermal warning flags; interrupt if high and enabled.
// - Thermal shutdown: SAFE, off, flag, count, interrupt.
// - After thermal shutdown, RESET on undervoltage if option.
// - Stays off until temperature below warning hysteresis.
`timescale 1ns/1ps
`default_nettype none
`include "srf_cfg.svh"
module srf_fault_ctrl import srf_pkg::*; #(
  parameter int SS_CYCLES = `SRF_SS_TIME_NS / `SRF_CLK_NS,
  parameter int OVP_OFF_CYCLES = `SRF_OVP_OFF_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog indications, asynchronous
  input wire logic wake,
  input wire logic wide_ramp_done,
  input wire logic stepdown_ov,
  input wire logic stepdown_uv,
  input wire logic stepup_uv,
  input wire logic stepup_ov,
  input wire logic stepup_ovp,
  input wire logic hs_overload,
  input wire logic ls_short,
  input wire logic hs_sink_ovc,
  input wire logic therm_warn,
  input wire logic therm_shutdown,
  input wire logic therm_below_hys,
  // Rail controls and device state
  output logic stepdown_on,
  output logic stepup_on,
  output logic ls_switch_off,
  output logic hs_hold_on,
  output logic [9:0] softstart_ref,
  output logic [1:0] device_state,
  output logic interrupt_out_n
);
  localparam int SINK_CYCLES = `SRF_SINK_TIME_NS / `SRF_CLK_NS;
  localparam int SS_STEP = (SS_CYCLES + 1022) / 1023;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  // ==========================================================
  // Input synchronisation
  logic [12:0] s;
  logic [12:0] s_q_ff;
  // Wake is carried inverted so that the synchroniser's cleared state reads as awake;
  // otherwise the block would fall into OFF on the first edge after every reset.
  srf_sync #(.WIDTH(13)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({~wake, wide_ramp_done, stepdown_ov, stepdown_uv, stepup_uv, stepup_ov, stepup_ovp,
      hs_overload, ls_short, hs_sink_ovc, therm_warn, therm_shutdown, therm_below_hys}),
    .sync_out(s)
  );
  wire s_wake = !s[12];
  wire s_ramp = s[11];
  wire s_sd_ov = s[10];
  wire s_sd_uv = s[9];
  wire s_su_uv = s[8];
  wire s_hs_ovl = s[5];
  wire s_ls_sc = s[4];
  wire s_sink = s[3];
  wire s_tw = s[2];
  wire s_tsd = s[1];
  wire s_cool = s[0];
  wire [12:0] rise = s & ~s_q_ff;

  // ==========================================================
  // State
  logic [`SRF_CTRL_W-1:0] ctrl_ff;
  logic [`SRF_ST_W-1:0] stat_ff;
  logic [`SRF_ST_W-1:0] nxt_stat;
  logic [`SRF_CTRL_W-1:0] nxt_ctrl;
  logic [7:0] err_ff;
  logic irq_ff;
  logic sd_pend_ff;
  logic su_pend_ff;
  logic therm_blk_ff;
  logic su_mask_ff;
  logic [15:0] ovp_cnt_ff;
  logic [15:0] sink_cnt_ff;
  logic [15:0] ss_pre_ff;
  logic [9:0] ss_ref_ff;
  logic [31:0] prdata_ff;
  srf_dev_state_t dev_ff;
  srf_dev_state_t nxt_dev;
  srf_sc_state_t sc_ff;
  srf_sc_state_t nxt_sc;

  // ==========================================================
  // APB decode
  wire wr = psel && penable && pwrite;
  wire hit_ctrl = paddr == `SRF_OFF_CTRL;
  wire hit_stat = paddr == `SRF_OFF_STAT;
  wire hit_state = paddr == `SRF_OFF_STATE;
  wire mapped = hit_ctrl || hit_stat || hit_state;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_stat = wr && hit_stat;
  wire sd_en = ctrl_ff[`SRF_CTRL_SD_EN];
  wire su_en = ctrl_ff[`SRF_CTRL_SU_EN];
  // On a write, enable bits move only when the lock is clear or cleared by the same write.
  wire unlock = !ctrl_ff[`SRF_CTRL_LOCK] || !pwdata[`SRF_CTRL_LOCK];
  wire su_set_req = wr_ctrl && unlock && pwdata[`SRF_CTRL_SU_EN] && !su_en;
  wire limit_now = s_hs_ovl || s_ls_sc;

  // ==========================================================
  // Fault events
  wire off_req = !s_wake || (ovp_cnt_ff == 16'(OVP_OFF_CYCLES - 1) && s_sd_ov && !sd_en);
  wire ovp_off_hit = s_sd_ov && !sd_en && ovp_cnt_ff == 16'(OVP_OFF_CYCLES - 1);
  wire sd_trip = rise[10] && sd_en;
  wire sink_evt = s_sink && !su_mask_ff;
  wire sink_to = sink_evt && sink_cnt_ff == 16'(SINK_CYCLES - 1);
  wire sc_start = sc_ff == SC_IDLE && stepup_on && (rise[4] || sink_to);
  wire sc_done = sc_ff == SC_DRAIN && !s_hs_ovl;
  wire th_trip = rise[1] && su_en;
  wire retry_fail = su_set_req && limit_now;
  wire warn_irq = rise[2] && irq_ff == 1'b0 && ctrl_ff[`SRF_CTRL_WARN_IRQ];
  wire any_err = sd_trip || sc_done || th_trip || retry_fail;
  wire shutdown = !s_wake || dev_ff == DEV_OFF;
  wire sd_to_reset = sd_pend_ff && s_sd_uv && ctrl_ff[`SRF_CTRL_SD_UVRST];
  wire su_to_reset = su_pend_ff && s_su_uv && ctrl_ff[`SRF_CTRL_SU_UVRST];

  // ==========================================================
  // Next values
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl[`SRF_CTRL_SD_UVRST] = pwdata[`SRF_CTRL_SD_UVRST];
      nxt_ctrl[`SRF_CTRL_SU_UVRST] = pwdata[`SRF_CTRL_SU_UVRST];
      nxt_ctrl[`SRF_CTRL_WARN_IRQ] = pwdata[`SRF_CTRL_WARN_IRQ];
      nxt_ctrl[`SRF_CTRL_LOCK] = pwdata[`SRF_CTRL_LOCK];
      if (unlock) begin
        nxt_ctrl[`SRF_CTRL_SD_EN] = pwdata[`SRF_CTRL_SD_EN];
        nxt_ctrl[`SRF_CTRL_SU_EN] = pwdata[`SRF_CTRL_SU_EN] && !limit_now;
      end
    end
    // Hardware clears win over a software write in the same cycle.
    if (sd_trip) begin
      nxt_ctrl[`SRF_CTRL_SD_EN] = 1'b0;
      nxt_ctrl[`SRF_CTRL_LOCK] = 1'b1;
    end
    if (sc_done || th_trip) begin
      nxt_ctrl[`SRF_CTRL_SU_EN] = 1'b0;
      nxt_ctrl[`SRF_CTRL_LOCK] = 1'b1;
    end
  end

  always_comb begin
    nxt_stat = stat_ff;
    if (wr_stat) begin
      nxt_stat[`SRF_ST_SD_LATCH-1:0] = stat_ff[`SRF_ST_SD_LATCH-1:0] & ~pwdata[`SRF_ST_SD_LATCH-1:0];
    end
    // Sets are applied last so an event in the clearing cycle survives.
    if (sd_trip) nxt_stat[`SRF_ST_SD_OVP] = 1'b1;
    if (rise[8]) nxt_stat[`SRF_ST_SU_UV] = 1'b1;
    if (rise[7]) nxt_stat[`SRF_ST_SU_OV] = 1'b1;
    if (rise[6]) nxt_stat[`SRF_ST_SU_OVP] = 1'b1;
    if (s_hs_ovl) nxt_stat[`SRF_ST_SU_OVL] = 1'b1;
    if (sc_done) nxt_stat[`SRF_ST_SU_SHORT] = 1'b1;
    if (sink_evt) nxt_stat[`SRF_ST_SU_SINK] = 1'b1;
    if (s_tw) nxt_stat[`SRF_ST_SU_WARN] = 1'b1;
    if (th_trip) nxt_stat[`SRF_ST_SU_TSD] = 1'b1;
    if (ovp_off_hit) nxt_stat[`SRF_ST_SD_LATCH] = 1'b1;
  end

  always_comb begin
    nxt_dev = dev_ff;
    case (dev_ff)
      DEV_OFF: nxt_dev = DEV_OFF;
      DEV_RESET: nxt_dev = DEV_ACTIVE;
      DEV_SAFE: begin
        if (sd_to_reset || su_to_reset) nxt_dev = DEV_RESET;
      end
      default: nxt_dev = dev_ff;
    endcase
    if (sd_trip || sc_done || th_trip) nxt_dev = DEV_SAFE;
    if (off_req) nxt_dev = DEV_OFF;
  end

  always_comb begin
    nxt_sc = sc_ff;
    case (sc_ff)
      SC_IDLE: begin
        if (sc_start) nxt_sc = SC_DRAIN;
      end
      SC_DRAIN: begin
        if (sc_done) nxt_sc = SC_IDLE;
      end
      default: nxt_sc = SC_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `SRF_CTRL_RST;
      stat_ff <= '0;
      dev_ff <= DEV_ACTIVE;
      sc_ff <= SC_IDLE;
      s_q_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      stat_ff <= nxt_stat;
      dev_ff <= nxt_dev;
      sc_ff <= nxt_sc;
      s_q_ff <= s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (any_err) err_ff <= sat_inc(err_ff);
      if (any_err || warn_irq) irq_ff <= 1'b1;
      else if (wr_stat && pwdata[`SRF_ST_IRQ_CLR]) irq_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_pend_ff <= 1'b0;
      su_pend_ff <= 1'b0;
      therm_blk_ff <= 1'b0;
      su_mask_ff <= 1'b0;
    end else begin
      if (sd_trip) sd_pend_ff <= 1'b1;
      else if (nxt_dev == DEV_RESET || sd_en) sd_pend_ff <= 1'b0;
      if (sc_done || th_trip) su_pend_ff <= 1'b1;
      else if (nxt_dev == DEV_RESET || su_en) su_pend_ff <= 1'b0;
      if (th_trip) therm_blk_ff <= 1'b1;
      else if (s_cool) therm_blk_ff <= 1'b0;
      if (nxt_ctrl[`SRF_CTRL_SU_EN] && !su_en) su_mask_ff <= 1'b1;
      else if (!s_su_uv) su_mask_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovp_cnt_ff <= '0;
      sink_cnt_ff <= '0;
    end else begin
      // Monitoring continues while the rail is disabled.
      ovp_cnt_ff <= (s_sd_ov && !sd_en && !ovp_off_hit) ? ovp_cnt_ff + 16'h0001 : 16'h0000;
      sink_cnt_ff <= (sink_evt && !sink_to) ? sink_cnt_ff + 16'h0001 : 16'h0000;
    end
  end

  // The ramp starts again from zero whenever the converter is not running,
  // so any restart after a fault also gets a full soft-start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_pre_ff <= '0;
      ss_ref_ff <= '0;
    end else if (shutdown || !stepup_on) begin
      ss_pre_ff <= '0;
      ss_ref_ff <= '0;
    end else if (ss_ref_ff != `SRF_REF_MAX) begin
      if (ss_pre_ff == 16'(SS_STEP - 1)) begin
        ss_pre_ff <= '0;
        ss_ref_ff <= ss_ref_ff + 10'h001;
      end else begin
        ss_pre_ff <= ss_pre_ff + 16'h0001;
      end
    end
  end

  // ==========================================================
  // APB read data and outputs
  wire [31:0] rd_mux = hit_ctrl ? {26'h0, ctrl_ff} :
    hit_stat ? {22'h0, stat_ff} :
    hit_state ? {6'h0, ss_ref_ff, err_ff, 6'h0, dev_ff} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_ff <= '0;
    else if (psel && !penable && !pwrite) prdata_ff <= rd_mux;
  end

  assign prdata = prdata_ff;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign stepdown_on = sd_en && dev_ff != DEV_OFF;
  assign stepup_on = su_en && s_ramp && !therm_blk_ff && sc_ff == SC_IDLE && dev_ff != DEV_OFF;
  assign ls_switch_off = sc_ff == SC_DRAIN;
  assign hs_hold_on = sc_ff == SC_DRAIN;
  assign softstart_ref = ss_ref_ff;
  assign device_state = dev_ff;
  assign interrupt_out_n = !irq_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_sd_trip_safe: assert property (sd_trip && !off_req |=> dev_ff == DEV_SAFE && !sd_en)
    else $error("step-down overvoltage did not shut down");
  chk_sd_trip_irq: assert property (sd_trip |=> !interrupt_out_n && err_ff != 8'h00)
    else $error("step-down overvoltage did not interrupt");
  chk_sd_uv_reset: assert property (dev_ff == DEV_SAFE && sd_to_reset && !off_req && !any_err
    |=> dev_ff == DEV_RESET)
    else $error("no reset after step-down undervoltage");
  chk_ovp_off: assert property (ovp_off_hit |=> dev_ff == DEV_OFF && stat_ff[`SRF_ST_SD_LATCH])
    else $error("persisting overvoltage did not reach off");
  chk_ss_hold: assert property (!s_ramp |=> ss_ref_ff == 10'h000)
    else $error("soft-start moved before wide ramp");
  chk_ss_restart: assert property (shutdown |=> ss_ref_ff == 10'h000)
    else $error("soft-start not restarted");
  chk_ovl_flag: assert property (s_hs_ovl && sc_ff == SC_IDLE && !th_trip && !retry_fail
    |=> stat_ff[`SRF_ST_SU_OVL] && $stable(su_en))
    else $error("overload flag missing or converter stopped");
  chk_sc_drain: assert property (sc_start |=> ls_switch_off && hs_hold_on && !stepup_on)
    else $error("short drain phase not entered");
  chk_sc_done: assert property (sc_done |=> stat_ff[`SRF_ST_SU_SHORT] && !su_en && !interrupt_out_n)
    else $error("short shutdown incomplete");
  chk_sink_limit: assert property (sink_cnt_ff <= 16'(SINK_CYCLES - 1))
    else $error("sink timer overran");
  chk_sink_mask: assert property (su_mask_ff && s_sink |-> !sink_evt ##1 sink_cnt_ff == 16'h0000)
    else $error("masked sink event counted");
  chk_retry_fail: assert property (retry_fail |=> !su_en && err_ff == sat_inc($past(err_ff)))
    else $error("retry under current limit not refused");
  chk_therm_block: assert property (therm_blk_ff |-> !stepup_on)
    else $error("converter ran during thermal block");
  chk_tsd_safe: assert property (th_trip && !off_req |=> dev_ff == DEV_SAFE && stat_ff[`SRF_ST_SU_TSD])
    else $error("thermal shutdown response missing");

  cov_sc_cycle: cover property (sc_start ##[1:20] sc_done);
  cov_ss_full: cover property (ss_ref_ff == `SRF_REF_MAX);
  cov_sd_reset: cover property (sd_trip ##[1:50] dev_ff == DEV_RESET);
  cov_warn_irq: cover property (warn_irq);
endmodule // srf_fault_ctrl
`default_nettype wire

// File: rtl/srf_sync.sv
// Two-stage synchroniser for a bundle of asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module srf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // srf_sync
`default_nettype wire

// File: shared/srf_cfg.svh
// Offsets, field positions, reset values and timing counts of the rail fault controller.
`ifndef SRF_CFG_SVH
`define SRF_CFG_SVH
// ==========================================================
// Register offsets
`define SRF_OFF_CTRL 8'h00
`define SRF_OFF_STAT 8'h04
`define SRF_OFF_STATE 8'h08
// ==========================================================
// Control register fields
`define SRF_CTRL_SD_EN 0
`define SRF_CTRL_SU_EN 1
`define SRF_CTRL_SD_UVRST 2
`define SRF_CTRL_SU_UVRST 3
`define SRF_CTRL_WARN_IRQ 4
`define SRF_CTRL_LOCK 5
`define SRF_CTRL_W 6
`define SRF_CTRL_RST 6'h02
// ==========================================================
// Status register fields
`define SRF_ST_SD_OVP 0
`define SRF_ST_SU_UV 1
`define SRF_ST_SU_OV 2
`define SRF_ST_SU_OVP 3
`define SRF_ST_SU_OVL 4
`define SRF_ST_SU_SHORT 5
`define SRF_ST_SU_SINK 6
`define SRF_ST_SU_WARN 7
`define SRF_ST_SU_TSD 8
`define SRF_ST_SD_LATCH 9
`define SRF_ST_W 10
`define SRF_ST_IRQ_CLR 31
// ==========================================================
// Timing
`define SRF_CLK_NS 20
`define SRF_SS_TIME_NS 2000000
`define SRF_SINK_TIME_NS 20000
`define SRF_OVP_OFF_CYC 1000
`define SRF_REF_MAX 10'h3FF
`endif

// File: shared/srf_pkg.sv
// Types shared by the rail fault controller.
package srf_pkg;
  typedef enum logic [1:0] {DEV_ACTIVE, DEV_SAFE, DEV_RESET, DEV_OFF} srf_dev_state_t;
  typedef enum logic {SC_IDLE, SC_DRAIN} srf_sc_state_t;
endpackage

// File: test/srf_mcu_model.sv
// Microcontroller model that drives the APB port of the rail fault controller.
`timescale 1ns/1ps
`default_nettype none
`include "srf_cfg.svh"
module srf_mcu_model (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt line driven by the controller
  input wire logic irq_n
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // ==========================================================
  // Transfers
  // The request is held until pready is seen, so slow slaves are served too.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Restart waits for the interrupt, then unlocks and enables in one write.
  task automatic restart(input logic [5:0] ctrl);
    logic [31:0] q;
    logic e;
    while (irq_n !== 1'b0) @(posedge pclk);
    xfer(1'b1, `SRF_OFF_CTRL, {26'h0, 1'b0, ctrl[4:0]}, q, e);
  endtask
endmodule // srf_mcu_model
`default_nettype wire

// File: test/stepup_rail_fault_control_bench.sv
// Self-checking bench for the rail fault controller.
`timescale 1ns/1ps
`default_nettype none
`include "srf_cfg.svh"
module stepup_rail_fault_control_bench;
  import srf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic wake, ramp, sd_ov, sd_uv, su_uv, su_ov, su_ovp, hs_ovl, ls_sc, sink, tw, tsd, thys;
  logic sd_on, su_on, ls_off, hs_hold, irq_n;
  logic [9:0] sref, r0;
  logic [1:0] dstate;
  logic [2:0] mon;
  int error_cnt, n_checks, exp_err, n;
  srf_fault_ctrl #(.SS_CYCLES(2046), .OVP_OFF_CYCLES(16)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake(wake), .wide_ramp_done(ramp),
    .stepdown_ov(sd_ov), .stepdown_uv(sd_uv), .stepup_uv(su_uv), .stepup_ov(su_ov),
    .stepup_ovp(su_ovp), .hs_overload(hs_ovl), .ls_short(ls_sc), .hs_sink_ovc(sink),
    .therm_warn(tw), .therm_shutdown(tsd), .therm_below_hys(thys), .stepdown_on(sd_on),
    .stepup_on(su_on), .ls_switch_off(ls_off), .hs_hold_on(hs_hold), .softstart_ref(sref),
    .device_state(dstate), .interrupt_out_n(irq_n));
  srf_mcu_model u_mcu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_n(irq_n));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_mcu.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    u_mcu.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic st(input int b, input logic v);
    rd(`SRF_OFF_STAT);
    chk(32'(q[b]), 32'(v));
  endtask
  // Expected state word: state and error counter, ramp field masked off.
  function automatic logic [31:0] exp_state(input logic [1:0] s);
    return {16'h0, exp_err[7:0], 6'h00, s};
  endfunction
  task automatic sv(input logic [1:0] s);
    rd(`SRF_OFF_STATE);
    chk(q & 32'h0000FF03, exp_state(s));
    chk(32'(dstate), 32'(s));
  endtask
  task automatic wait_st(input logic [1:0] s);
    for (int i = 0; i < 20 && dstate !== s; i++) cyc(1);
    chk(32'(dstate), 32'(s));
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    {sd_ov, sd_uv, su_uv, su_ov, su_ovp, hs_ovl, ls_sc, sink, tw, tsd} <= '0;
    thys <= 1'b1;
    wake <= 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    exp_err = 0;
    cyc(3);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    final_report();
  end
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(75961));
    {presetn, ramp, sd_ov, sd_uv, su_uv, su_ov, su_ovp, hs_ovl, ls_sc, sink, tw, tsd} = '0;
    mon = 3'h0;
    wake = 1'b1;
    thys = 1'b1;
    do_reset();
    rd(`SRF_OFF_CTRL);
    chk(q, 32'h00000002);
    chk(32'(su_on), 32'h0);
    rd(8'h0C);
    chk({q[30:0], e}, 32'h1);
    wr(`SRF_OFF_CTRL, 32'h0);
    rd(`SRF_OFF_CTRL);
    chk(q, 32'h0);
    wr(`SRF_OFF_CTRL, 32'h2);
    @(posedge pclk);
    ramp <= 1'b1;
    cyc(8);
    chk(32'(su_on), 32'h1);
    r0 = sref;
    cyc(200);
    chk(32'((sref - r0) inside {[10'd99:10'd101]}), 32'h1);
    cyc(2100);
    chk(32'(sref), 32'h3FF);
    wr(`SRF_OFF_CTRL, 32'h0);
    cyc(3);
    chk(32'(sref), 32'h0);
    wr(`SRF_OFF_CTRL, 32'h07);
    @(posedge pclk);
    sd_ov <= 1'b1;
    cyc(1);
    chk(32'(sd_on), 32'h1);
    cyc(4);
    sd_ov <= 1'b0;
    exp_err = 1;
    chk({29'h0, sd_on, irq_n, ~u_dut.presetn}, 32'h0);
    sv(DEV_SAFE);
    st(`SRF_ST_SD_OVP, 1'b1);
    @(posedge pclk);
    sd_uv <= 1'b1;
    wait_st(DEV_RESET);
    sd_uv <= 1'b0;
    wr(`SRF_OFF_CTRL, 32'h27);
    chk(32'(sd_on), 32'h0);
    u_mcu.restart(6'h07);
    cyc(2);
    chk(32'(sd_on), 32'h1);
    wr(`SRF_OFF_STAT, 32'h800001FF);
    cyc(1);
    chk(32'(irq_n), 32'h1);
    @(posedge pclk);
    sd_ov <= 1'b1;
    cyc(40);
    chk(32'(dstate), 32'(DEV_OFF));
    st(`SRF_ST_SD_LATCH, 1'b1);
    do_reset();
    // Random mix of monitor events; bits [3:1] of status must mirror it.
    for (int i = 0; i < 3; i++) begin
      n = $urandom_range(6, 3);
      mon = 3'($urandom_range(7, 1));
      @(posedge pclk);
      {su_ovp, su_ov, su_uv} <= mon;
      cyc(n);
      {su_ovp, su_ov, su_uv} <= 3'h0;
      rd(`SRF_OFF_STAT);
      chk(32'(q[`SRF_ST_SU_OVP:`SRF_ST_SU_UV]), 32'(mon));
      wr(`SRF_OFF_STAT, 32'h000001FF);
    end
    @(posedge pclk);
    hs_ovl <= 1'b1;
    cyc(5);
    st(`SRF_ST_SU_OVL, 1'b1);
    chk(32'(su_on), 32'h1);
    @(posedge pclk);
    ls_sc <= 1'b1;
    cyc(5);
    chk({ls_off, hs_hold}, 32'h3);
    ls_sc <= 1'b0;
    hs_ovl <= 1'b0;
    cyc(5);
    exp_err = 1;
    chk({ls_off, hs_hold, irq_n}, 32'h0);
    sv(DEV_SAFE);
    st(`SRF_ST_SU_SHORT, 1'b1);
    @(posedge pclk);
    hs_ovl <= 1'b1;
    wr(`SRF_OFF_CTRL, 32'h08);
    u_mcu.restart(6'h0A);
    rd(`SRF_OFF_CTRL);
    chk(32'(q[1]), 32'h0);
    exp_err = 2;
    sv(DEV_SAFE);
    hs_ovl <= 1'b0;
    su_uv <= 1'b1;
    wait_st(DEV_RESET);
    wr(`SRF_OFF_STAT, 32'h000001FF);
    u_mcu.restart(6'h0A);
    @(posedge pclk);
    sink <= 1'b1;
    cyc(1100);
    chk(32'(su_on), 32'h1);
    st(`SRF_ST_SU_SINK, 1'b0);
    su_uv <= 1'b0;
    cyc(900);
    chk(32'(su_on), 32'h1);
    st(`SRF_ST_SU_SINK, 1'b1);
    cyc(200);
    exp_err = 3;
    sv(DEV_SAFE);
    st(`SRF_ST_SU_SHORT, 1'b1);
    do_reset();
    wr(`SRF_OFF_CTRL, 32'h12);
    @(posedge pclk);
    tw <= 1'b1;
    cyc(5);
    tw <= 1'b0;
    chk(32'(irq_n), 32'h0);
    st(`SRF_ST_SU_WARN, 1'b1);
    sv(DEV_ACTIVE);
    wr(`SRF_OFF_STAT, 32'h800001FF);
    wr(`SRF_OFF_CTRL, 32'h0A);
    tw <= 1'b1;
    cyc(5);
    chk(32'(irq_n), 32'h1);
    tw <= 1'b0;
    thys <= 1'b0;
    tsd <= 1'b1;
    cyc(5);
    tsd <= 1'b0;
    exp_err = 1;
    chk({su_on, irq_n}, 32'h0);
    sv(DEV_SAFE);
    st(`SRF_ST_SU_TSD, 1'b1);
    su_uv <= 1'b1;
    wait_st(DEV_RESET);
    su_uv <= 1'b0;
    u_mcu.restart(6'h0A);
    cyc(10);
    chk(32'(su_on), 32'h0);
    thys <= 1'b1;
    cyc(5);
    chk(32'(su_on), 32'h1);
    wake <= 1'b0;
    cyc(5);
    chk({dstate, su_on, sref}, {DEV_OFF, 11'h0});
    final_report();
  end
endmodule // stepup_rail_fault_control_bench
`default_nettype wire
